//--- cascaded_twelve_bit_pwm.sv
// Functional notes
// (R1) Cascade bit joins timers, upper settings rule
// (R2) Mode pattern 10 selects twelve-bit PWM
// (R3) Clock source: prescaled internal or external pin
// (R4) Run starts count; mode writes ignored
// (R5) Compare built from high nibble, low byte
// (R6) High write transfers combined value at once
// (R7) Software writes low then high register
// (R8) High register upper nibble stored, read back
// (R9) Upper eight bits are duty value
// (R10) Extra bits select stretched cycles in frame
// (R11) No extra bits means no stretching
// (R12) Initial level select chooses low or high
// (R13) Stopped timer drives initial level out
// (R14) Count equals duty inverts output
// (R15) Stretched cycle inverts at duty plus one
// (R16) Count 256 overflows, clears, restores level
// (R17) Overflow request on every overflow
// (R18) Frame request every sixteenth overflow
// (R19) Clearing run stops, clears, restores level
// (R20) Double buffer loads at frame end
// (R21) Otherwise compare applies immediately
// (R22) Reads return last written value; compare reads return the buffered pair, which only a high write loads
// (R23) Cycle index advances per overflow, resets
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module cascaded_twelve_bit_pwm #(
    parameter int PRESCALE_W = 12
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_b,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic       i_ext_clk,
    input  wire logic       i_pin_func_sel,
    output logic      [7:0] o_rdata,
    output logic            o_pwm_out_n,
    output logic            o_pwm_out_oe_n,
    output logic            o_overflow_irq,
    output logic            o_frame_end_irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    pwm12_pkg::upper_timer_mode_t       mode_reg;
    logic [7:0]                         ctrl_reg;
    logic [7:0]                         low_wr_reg;
    pwm12_pkg::combined_compare_value_t buf_reg;
    pwm12_pkg::combined_compare_value_t act_reg;
    logic [7:0]                         cnt_reg;
    logic [3:0]                         idx_reg;
    logic                               dutied_reg;
    logic [PRESCALE_W-1:0]              pre_reg;
    logic [1:0]                         ext_sync_reg;
    logic                               ext_prev_reg;
    logic                               pwm_reg;

    logic       running;
    logic       pwm_mode;
    logic       tick;
    logic       wr_low;
    logic       wr_high;
    logic       wr_mode;
    logic       wr_ctrl;
    logic [7:0] duty_value;
    logic       stretch;
    logic       match;
    logic       ovf;
    logic       frame_end;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic cycle_selected(input logic [3:0] idx,
                                            input logic [3:0] ad);
        logic [4:0] c;
        c = {1'b0, idx} + 5'h01;
        cycle_selected = (ad[0] && c == 5'h09) ||
                         (ad[1] && c[2:0] == 3'h5) ||
                         (ad[2] && c[1:0] == 2'h3) ||
                         (ad[3] && c[0] == 1'b0);
    endfunction

    assign wr_low  = i_wr && hit(i_addr, pwm12_pkg::ADDR_LOW_CMP);
    assign wr_high = i_wr && hit(i_addr, pwm12_pkg::ADDR_HIGH_CMP);
    assign wr_mode = i_wr && hit(i_addr, pwm12_pkg::ADDR_MODE);
    assign wr_ctrl = i_wr && hit(i_addr, pwm12_pkg::ADDR_CTRL);

    // Once cascaded, the only lower timer setting that plays a part is the lower run bit, which blocks mode writes [R1]
    assign pwm_mode = ctrl_reg[pwm12_pkg::CASCADE_BIT] &&
                      (mode_reg.mode_select == pwm12_pkg::MODE_PWM12); // [R1] [R2]
    assign running  = ctrl_reg[pwm12_pkg::UPPER_RUN_BIT] && pwm_mode; // [R4]

    // ------------------------------------------------------------
    // Control and mode registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            ctrl_reg <= pwm12_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= i_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            mode_reg <= pwm12_pkg::MODE_RST;
        end else if (wr_mode && !ctrl_reg[pwm12_pkg::UPPER_RUN_BIT]
                     && !ctrl_reg[pwm12_pkg::LOWER_RUN_BIT]) begin
            mode_reg <= i_wdata; // [R4]
        end
    end

    // ------------------------------------------------------------
    // Compare registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            low_wr_reg <= pwm12_pkg::LOW_CMP_RST;
        end else if (wr_low) begin
            low_wr_reg <= i_wdata; // [R7]
        end
    end

    // Buffer holds the last written pair; readback comes from here
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            buf_reg <= {pwm12_pkg::HIGH_CMP_RST, pwm12_pkg::LOW_CMP_RST};
        end else if (wr_high) begin
            buf_reg <= {i_wdata, low_wr_reg}; // [R5] [R6] [R8]
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            act_reg <= {pwm12_pkg::HIGH_CMP_RST, pwm12_pkg::LOW_CMP_RST};
        end else if (wr_high && (!running || !mode_reg.double_buffer_enable)) begin
            act_reg <= {i_wdata, low_wr_reg}; // [R21]
        end else if (frame_end && mode_reg.double_buffer_enable) begin
            act_reg <= buf_reg; // [R20]
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            if (hit(i_addr, pwm12_pkg::ADDR_LOW_CMP)) begin
                o_rdata <= buf_reg[7:0]; // [R22]
            end else if (hit(i_addr, pwm12_pkg::ADDR_HIGH_CMP)) begin
                o_rdata <= buf_reg[15:8]; // [R8] [R22]
            end else if (hit(i_addr, pwm12_pkg::ADDR_MODE)) begin
                o_rdata <= mode_reg;
            end else if (hit(i_addr, pwm12_pkg::ADDR_CTRL)) begin
                o_rdata <= ctrl_reg;
            end else begin
                o_rdata <= 8'h00;
            end
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Source clock
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            ext_sync_reg <= 2'h0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_sync_reg <= {ext_sync_reg[0], i_ext_clk};
            ext_prev_reg <= ext_sync_reg[1];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || !running) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 1'b1;
        end
    end

    // Prescale code 7 is the raw clock; codes 6 down to 0 divide by 2, 4, 16, 64, 256, 1024, 2048
    always_comb begin
        logic [3:0] sh;
        sh = 4'h0;
        unique case (mode_reg.prescale_select)
            3'h0: sh = 4'hb;
            3'h1: sh = 4'ha;
            3'h2: sh = 4'h8;
            3'h3: sh = 4'h6;
            3'h4: sh = 4'h4;
            3'h5: sh = 4'h2;
            3'h6: sh = 4'h1;
            3'h7: sh = 4'h0;
        endcase
        if (mode_reg.external_clock_select) begin
            tick = ext_prev_reg && !ext_sync_reg[1]; // [R3]
        end else if (sh == 4'h0) begin
            tick = 1'b1; // [R3]
        end else begin
            tick = (pre_reg & ((PRESCALE_W'(1) << sh) - 1'b1)) ==
                   ((PRESCALE_W'(1) << sh) - 1'b1); // [R3]
        end
    end

    // ------------------------------------------------------------
    // Counter and frame index
    // ------------------------------------------------------------
    assign duty_value = {act_reg.duty_high_nibble, act_reg.duty_low_nibble}; // [R9]
    assign stretch    = cycle_selected(idx_reg, act_reg.extra_pulse_bits); // [R10] [R11]
    assign ovf        = running && tick && (cnt_reg == 8'hff); // [R16]
    assign frame_end  = ovf && (idx_reg == 4'hf); // [R18]
    // Stretch delays the match by one source clock [R15]
    assign match      = running && tick && !dutied_reg &&
                        (stretch ? dutied_pending() : (cnt_reg == duty_value)); // [R14]

    function automatic logic dutied_pending();
        dutied_pending = (cnt_reg == duty_value + 8'h01) && (duty_value != 8'hff);
    endfunction

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || !running) begin
            cnt_reg <= pwm12_pkg::CNT_ZERO; // [R19]
        end else if (tick) begin
            cnt_reg <= cnt_reg + 8'h01; // [R16]
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || !running) begin
            idx_reg <= pwm12_pkg::IDX_FIRST; // [R23]
        end else if (ovf) begin
            idx_reg <= idx_reg + 4'h1; // [R23]
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || !running || ovf) begin
            dutied_reg <= 1'b0;
        end else if (match) begin
            dutied_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Output pin and requests
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            pwm_reg <= 1'b0;
        end else if (!running || ovf) begin
            pwm_reg <= mode_reg.initial_level_select; // [R12] [R13] [R16] [R19]
        end else if (match) begin
            pwm_reg <= !mode_reg.initial_level_select; // [R14]
        end
    end

    assign o_pwm_out_n = pwm_reg;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_pwm_out_oe_n <= 1'b1;
        end else begin
            o_pwm_out_oe_n <= !i_pin_func_sel; // [R13]
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_overflow_irq  <= 1'b0;
            o_frame_end_irq <= 1'b0;
        end else begin
            o_overflow_irq  <= ovf; // [R17]
            o_frame_end_irq <= frame_end; // [R18]
        end
    end

endmodule

//--- cascaded_twelve_bit_pwm_asserts.sv
`timescale 1ns/1ps
module cascaded_twelve_bit_pwm_asserts #(
    parameter int PRESCALE_W = 12
) (
    input wire logic       i_ref_clk,
    input wire logic       i_rst_b,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic       i_ext_clk,
    input wire logic       i_pin_func_sel,
    input wire logic [7:0] o_rdata,
    input wire logic       o_pwm_out_n,
    input wire logic       o_pwm_out_oe_n,
    input wire logic       o_overflow_irq,
    input wire logic       o_frame_end_irq
);
    // ------------------------------------------------------------
    // Shadow state
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic [7:0] mode_reg;
    logic [7:0] hi_reg;
    logic [3:0] ovf_reg;
    logic [1:0] quiet_reg;
    logic       run;
    logic       tff;
    assign run = ctrl_reg[0] & ctrl_reg[2] & (mode_reg[1:0] == pwm12_pkg::MODE_PWM12);
    assign tff = mode_reg[2];
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            ctrl_reg <= pwm12_pkg::CTRL_RST;
            mode_reg <= pwm12_pkg::MODE_RST;
            hi_reg   <= pwm12_pkg::HIGH_CMP_RST;
        end else if (i_wr) begin
            if (i_addr == pwm12_pkg::ADDR_CTRL)
                ctrl_reg <= i_wdata;
            if (i_addr == pwm12_pkg::ADDR_MODE && ctrl_reg[2:1] == 2'h0)
                mode_reg <= i_wdata;
            if (i_addr == pwm12_pkg::ADDR_HIGH_CMP)
                hi_reg <= i_wdata;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || !run)
            ovf_reg <= 4'h0;
        else if (o_overflow_irq)
            ovf_reg <= ovf_reg + 4'h1;
    end
    // Cycles since last mode or control write (0x2a, 0x2b)
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || (i_wr && i_addr[7:1] == 7'h15))
            quiet_reg <= 2'h0;
        else if (quiet_reg != 2'h3)
            quiet_reg <= quiet_reg + 2'h1;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_stop;
        run ##1 !run;
    endsequence
    property p_ovf_pulse;
        o_overflow_irq |=> !o_overflow_irq [*8];
    endproperty
    property p_frame;
        o_overflow_irq |-> (o_frame_end_irq == (ovf_reg == 4'hf));
    endproperty
    property p_frame_only;
        o_frame_end_irq |-> o_overflow_irq && run;
    endproperty
    property p_ovf_level;
        o_overflow_irq |-> o_pwm_out_n == tff;
    endproperty
    property p_stopped;
        (!run && quiet_reg == 2'h3) |-> o_pwm_out_n == tff;
    endproperty
    property p_inv;
        run && $changed(o_pwm_out_n) && !o_overflow_irq |-> o_pwm_out_n != tff;
    endproperty
    property p_stop;
        s_stop |-> ##[0:2] (o_pwm_out_n == tff);
    endproperty
    property p_rd_hi;
        $past(i_rd) && $past(i_addr) == pwm12_pkg::ADDR_HIGH_CMP |-> o_rdata == hi_reg;
    endproperty
    property p_rd_mode;
        $past(i_rd) && $past(i_addr) == pwm12_pkg::ADDR_MODE |-> o_rdata == mode_reg;
    endproperty
    a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow pulse too long");
    a_frame: assert property (p_frame) else $error("frame request misplaced");
    a_frame_only: assert property (p_frame_only) else $error("stray frame request");
    a_ovf_level: assert property (p_ovf_level) else $error("overflow level wrong");
    a_stopped: assert property (p_stopped) else $error("stopped level wrong");
    a_inv: assert property (p_inv) else $error("bad pin inversion");
    a_stop: assert property (p_stop) else $error("stop did not restore");
    a_rd_hi: assert property (p_rd_hi) else $error("high readback wrong");
    a_rd_mode: assert property (p_rd_mode) else $error("mode write not refused");
endmodule
bind cascaded_twelve_bit_pwm cascaded_twelve_bit_pwm_asserts #(.PRESCALE_W(PRESCALE_W)) chk_i (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_ext_clk(i_ext_clk), .i_pin_func_sel(i_pin_func_sel),
    .o_rdata(o_rdata), .o_pwm_out_n(o_pwm_out_n), .o_pwm_out_oe_n(o_pwm_out_oe_n),
    .o_overflow_irq(o_overflow_irq), .o_frame_end_irq(o_frame_end_irq));

//--- cascaded_twelve_bit_pwm_tb.sv
`timescale 1ns/1ps
module cascaded_twelve_bit_pwm_tb;
    logic       i_ref_clk = 1'b0;
    logic       i_rst_b = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic       i_ext_clk = 1'b0;
    logic       i_pin_func_sel = 1'b1;
    logic [7:0] o_rdata;
    logic       o_pwm_out_n, o_pwm_out_oe_n, o_overflow_irq, o_frame_end_irq;
    logic       lvl;
    int         len, events, ev_last, err_total, n_compared, seed_v;
    always #4 i_ref_clk = ~i_ref_clk;
    // External source clock: one falling edge every four reference clocks
    always begin
        repeat (2) @(posedge i_ref_clk);
        i_ext_clk <= ~i_ext_clk;
    end
    cascaded_twelve_bit_pwm #(.PRESCALE_W(12)) cascaded_twelve_bit_pwm_i (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_ext_clk(i_ext_clk), .i_pin_func_sel(i_pin_func_sel),
        .o_rdata(o_rdata), .o_pwm_out_n(o_pwm_out_n), .o_pwm_out_oe_n(o_pwm_out_oe_n),
        .o_overflow_irq(o_overflow_irq), .o_frame_end_irq(o_frame_end_irq));
    pwm_load pwm_load_i (.i_ref_clk(i_ref_clk), .i_pin(o_pwm_out_n), .i_oe_n(o_pwm_out_oe_n),
        .o_len(len), .o_lvl(lvl), .o_events(events));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic close_out;
        $display("compares %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 chk({24'h0, o_rdata}, {24'h0, e});
    endtask
    function automatic int stretch(int ad, int k);
        return ((ad & 1) && k == 9) || ((ad & 2) && k % 8 == 5) ||
               ((ad & 4) && k % 4 == 3) || ((ad & 8) && k % 2 == 0);
    endfunction
    task automatic wait_act(input logic a);
        int n;
        for (n = 0; n < 2100; n++) begin
            @(posedge i_ref_clk);
            #1;
            if (events != ev_last && lvl === a)
                break;
        end
        if (n == 2100) begin
            err_total++;
            close_out();
        end
        ev_last = events;
    endtask
    task automatic run_cfg(input int tff, input int dbe, input int ad, input int ext);
        int d, nd, nad, k, h;
        logic [7:0] m;
        m = 8'he2 | 8'(ext << 4) | 8'(dbe << 3) | 8'(tff << 2);
        d = 1 + $urandom % 240;
        h = $urandom % 16;
        wr(pwm12_pkg::ADDR_MODE, m);
        wr(pwm12_pkg::ADDR_LOW_CMP, {d[3:0], ad[3:0]});
        wr(pwm12_pkg::ADDR_HIGH_CMP, {h[3:0], d[7:4]});
        rd(pwm12_pkg::ADDR_HIGH_CMP, {h[3:0], d[7:4]});
        wr(pwm12_pkg::ADDR_CTRL, 8'h05);
        ev_last = events;
        wr(pwm12_pkg::ADDR_MODE, m ^ 8'h04);
        for (k = 1; k <= 20; k++) begin
            wait_act(!tff[0]);
            chk(len, (32'hff - d - stretch(ad, (k - 1) % 16 + 1)) * (ext ? 4 : 1));
            if (dbe && k == 8) begin
                nd = 1 + $urandom % 240;
                nad = $urandom % 16;
                wr(pwm12_pkg::ADDR_LOW_CMP, {nd[3:0], nad[3:0]});
                wr(pwm12_pkg::ADDR_HIGH_CMP, {4'h0, nd[7:4]});
                rd(pwm12_pkg::ADDR_LOW_CMP, {nd[3:0], nad[3:0]});
            end
            if (dbe && k == 16) begin
                d = nd;
                ad = nad;
            end
        end
        wr(pwm12_pkg::ADDR_CTRL, 8'h00);
        repeat (3) @(posedge i_ref_clk);
        #1 chk({31'h0, o_pwm_out_n}, 32'(tff));
        rd(pwm12_pkg::ADDR_MODE, m);
        $display("run done tff=%0d dbe=%0d extra=%h", tff, dbe, ad);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed_v = $urandom(32'h22dd9366);
        repeat (4) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        rd(pwm12_pkg::ADDR_LOW_CMP, pwm12_pkg::LOW_CMP_RST);
        rd(pwm12_pkg::ADDR_HIGH_CMP, pwm12_pkg::HIGH_CMP_RST);
        rd(pwm12_pkg::ADDR_MODE, pwm12_pkg::MODE_RST);
        rd(pwm12_pkg::ADDR_CTRL, pwm12_pkg::CTRL_RST);
        rd(8'h30, 8'h00);
        chk({31'h0, o_pwm_out_oe_n}, 32'h0);
        $display("reset values done");
        run_cfg(0, 0, 0, 0);
        run_cfg(1, 0, 1, 0);
        run_cfg(0, 0, 2, 0);
        run_cfg(1, 0, 4, 1);
        run_cfg(0, 1, 8, 0);
        run_cfg(1, 1, $urandom % 16, 0);
        close_out();
    end
endmodule

//--- pwm12_pkg.sv
package pwm12_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LOW_CMP  = 8'h28;
    localparam logic [7:0] ADDR_HIGH_CMP = 8'h29;
    localparam logic [7:0] ADDR_MODE     = 8'h2a;
    localparam logic [7:0] ADDR_CTRL     = 8'h2b;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] LOW_CMP_RST   = 8'hff;
    localparam logic [7:0] HIGH_CMP_RST  = 8'hff;
    localparam logic [7:0] MODE_RST      = 8'h00;
    localparam logic [7:0] CTRL_RST      = 8'h00;
    localparam logic [1:0] MODE_PWM12    = 2'h2;

    localparam int MODE_SEL_LSB  = 0;
    localparam int TFF_BIT       = 2;
    localparam int DBE_BIT       = 3;
    localparam int EXT_CLK_BIT   = 4;
    localparam int PRESCALE_LSB  = 5;
    localparam int LOWER_RUN_BIT = 1;
    localparam int UPPER_RUN_BIT = 2;
    localparam int CASCADE_BIT   = 0;

    localparam logic [7:0] CNT_ZERO  = 8'h00;
    localparam logic [3:0] IDX_FIRST = 4'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] prescale_select;
        logic       external_clock_select;
        logic       double_buffer_enable;
        logic       initial_level_select;
        logic [1:0] mode_select;
    } upper_timer_mode_t;

    typedef struct packed {
        logic [3:0] hi_unused;
        logic [3:0] duty_high_nibble;
        logic [3:0] duty_low_nibble;
        logic [3:0] extra_pulse_bits;
    } combined_compare_value_t;

endpackage

//--- pwm_load.sv
`timescale 1ns/1ps
// Load on the pin: length in clocks of each finished level run
module pwm_load (
    input  wire logic i_ref_clk,
    input  wire logic i_pin,
    input  wire logic i_oe_n,
    output int        o_len,
    output logic      o_lvl,
    output int        o_events
);
    logic prev_reg = 1'b0;
    int   run_reg  = 0;
    always @(posedge i_ref_clk) begin
        if (!i_oe_n && i_pin !== prev_reg) begin
            o_len    <= run_reg;
            o_lvl    <= prev_reg;
            o_events <= o_events + 1;
            run_reg  <= 1;
        end else begin
            run_reg <= run_reg + 1;
        end
        prev_reg <= i_pin;
    end
endmodule
